/* File: src/hsf_pkg.sv */
// Purpose: Shared constants and types of the hub string and feature register bank.
// Assumes: A single core clock of 125 MHz.
// Notes: Offsets are the byte addresses of the configuration byte port.
package hsf_pkg;
    // Register offsets.
    localparam logic [7:0] HSF_SERIAL_BASE = 8'h30;
    localparam logic [7:0] HSF_SERIAL_LAST = 8'h4f;
    localparam logic [7:0] HSF_MAKER_BASE = 8'h50;
    localparam logic [7:0] HSF_MAKER_LAST = 8'h8f;
    localparam logic [7:0] HSF_PRODUCT_BASE = 8'h90;
    localparam logic [7:0] HSF_PRODUCT_LAST = 8'hcf;
    localparam logic [7:0] HSF_FEATURE_OFS = 8'hf0;
    localparam logic [7:0] HSF_CHARGE_OFS = 8'hf2;
    // Text array layout, indexed by offset minus the serial base.
    localparam int HSF_TEXT_BYTES = 160;
    localparam logic [7:0] HSF_SERIAL_IDX0 = 8'h00;
    localparam logic [7:0] HSF_MAKER_IDX0 = 8'h20;
    localparam logic [7:0] HSF_PRODUCT_IDX0 = 8'h60;
    localparam logic [6:0] HSF_SERIAL_MAX = 7'h20;
    // Reset values.
    localparam logic [7:0] HSF_TEXT_RESET = 8'h00;
    localparam logic [7:0] HSF_FEATURE_RESET = 8'h00;
    localparam logic [7:0] HSF_CHARGE_RESET = 8'h00;
    // Field positions.
    localparam int HSF_SPREAD_BIT = 0;
    localparam int HSF_DELAY_LSB = 1;
    localparam int HSF_DELAY_MSB = 3;
    localparam int HSF_CHARGE_MSB = 3;
    // String descriptor indices.
    localparam logic [1:0] HSF_IDX_SERIAL = 2'h1;
    localparam logic [1:0] HSF_IDX_PRODUCT = 2'h2;
    localparam logic [1:0] HSF_IDX_MAKER = 2'h3;
    // Timing.
    localparam int HSF_CLK_HZ = 125000000;
    localparam int HSF_DELAY_STEP_MS = 200;
    localparam int HSF_DELAY_STEP_CYCLES = (HSF_CLK_HZ / 1000) * HSF_DELAY_STEP_MS;
    localparam logic [1:0] HSF_BOOT_LOAD = 2'h2;
    typedef enum logic [0:0] {
        HSF_PWR_RUN = 1'b0,
        HSF_PWR_HOLD = 1'b1
    } hsf_pwr_state_t;
endpackage

/* File: src/hsf_tick_div.sv */
// Purpose: Restartable divider giving a one-cycle enable every PERIOD clocks.
// Assumes: restart comes from logic on the same clock.
// Notes: The first tick after a restart comes PERIOD cycles after the restart edge.
`timescale 1ns/1ps
module hsf_tick_div #(
    parameter int unsigned PERIOD = 25000000
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Control.
    input wire logic restart,
    output logic tick
);
    localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_q;

    assign tick = (cnt_q == LAST) && !restart;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (restart || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    property p_tick_spacing;
        @(posedge mclk) disable iff (!nrst)
        restart |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick right after restart");
endmodule

/* File: src/hsf_regs.sv */
// Purpose: String byte, spread spectrum and charging delay register bank of a two-port hub.
// Assumes: Length fields, options and the byte port come from core logic; scl_pin is a raw pin.
// Notes: Strings are fetched one byte at a time; answers come one cycle after the request.
// Notes on behaviour
// - Serial bytes sit in one contiguous array and are the string returned at index 1.
// - Serial bytes accept writes only while the custom serial option is 1.
// - Maker bytes form the string at index 3 only when the maker length is non-zero.
// - Exactly maker-length bytes are returned from the first maker byte on; past the 64 maker bytes they come from the product bytes.
// - Product bytes form the string at index 2 only when the product length is non-zero.
// - Exactly product-length bytes are returned from the first product byte on; positions past the 64 product bytes lie outside the text array.
// - Spread spectrum stays on while the spread-disable bit is 0 and is off when it is 1.
// - At reset release the spread-disable bit is loaded from the serial clock pin level.
// - Reserved read-only bits always read as zero.
// - The power-on delay is the three-bit field plus one, times 200 ms.
// - On a charging mode change with charge control on, port power is held off for that delay.
// - The delay field may be written by the EEPROM loader or the SMBus host.
// - A non-zero serial length returns that many serial bytes at index 1, at most 32.
`timescale 1ns/1ps
module hsf_regs
    import hsf_pkg::*;
#(
    parameter int unsigned DELAY_STEP_CYCLES = HSF_DELAY_STEP_CYCLES,
    // Factory serial byte value; arbitrary.
    parameter logic [7:0] SERIAL_RESET_BYTE = 8'h00
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Configuration byte port.
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_ack,
    // Options and string lengths.
    input wire logic custom_serial_option,
    input wire logic [5:0] serial_text_length,
    input wire logic [6:0] maker_text_length,
    input wire logic [6:0] product_text_length,
    // String byte fetch.
    input wire logic str_req,
    input wire logic [1:0] str_index,
    input wire logic [6:0] str_pos,
    output logic str_ack,
    output logic str_present,
    output logic [7:0] str_byte,
    // Pins and feature controls.
    input wire logic scl_pin,
    output logic spread_disable,
    // Charging power control.
    input wire logic downstream_charge_ctrl_enable,
    input wire logic charge_mode_change,
    input wire logic port_power_request,
    output logic port_power_enable
);
    logic [7:0] text_mem [0:HSF_TEXT_BYTES-1];
    logic [7:0] feature_q;
    logic [7:0] charge_q;
    logic scl_s1_q;
    logic scl_s2_q;
    logic [1:0] boot_q;
    logic [7:0] rdata_q;
    logic rack_q;
    logic sack_q;
    logic spres_q;
    logic [7:0] sbyte_q;
    logic pwr_q;
    hsf_pwr_state_t state_q;
    hsf_pwr_state_t state_d;
    logic [3:0] steps_q;
    logic step_tick;
    logic start;
    logic in_serial;
    logic in_text;
    logic [7:0] text_idx;
    logic text_wr;
    logic [7:0] rdata_d;
    logic [6:0] serial_len;
    logic [6:0] sel_len;
    logic [7:0] sel_base;
    logic sel_ok;
    logic [7:0] fetch_idx;

    assign cfg_rdata = rdata_q;
    assign cfg_ack = rack_q;
    assign str_ack = sack_q;
    assign str_present = spres_q;
    assign str_byte = sbyte_q;
    assign spread_disable = feature_q[HSF_SPREAD_BIT];
    assign port_power_enable = pwr_q;

    // Serial, maker and product arrays are one block from the serial base upward.
    assign in_serial = (cfg_addr >= HSF_SERIAL_BASE) && (cfg_addr <= HSF_SERIAL_LAST);
    assign in_text = (cfg_addr >= HSF_SERIAL_BASE) && (cfg_addr <= HSF_PRODUCT_LAST);
    assign text_idx = cfg_addr - HSF_SERIAL_BASE;
    assign text_wr = cfg_wr && in_text && (!in_serial || custom_serial_option);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < HSF_TEXT_BYTES; i++) begin
                text_mem[i] <= (i < int'(HSF_MAKER_IDX0)) ? SERIAL_RESET_BYTE : HSF_TEXT_RESET;
            end
        end else if (text_wr) begin
            text_mem[text_idx] <= cfg_wdata;
        end
    end

    // Serial clock pin is sampled through two flops before the boot load reads it.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_s1_q <= 1'b0;
            scl_s2_q <= 1'b0;
        end else begin
            scl_s1_q <= scl_pin;
            scl_s2_q <= scl_s1_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boot_q <= 2'h0;
        end else if (boot_q != 2'h3) begin
            boot_q <= boot_q + 2'h1;
        end
    end

    // The boot load wins over a write in the same cycle.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            feature_q <= HSF_FEATURE_RESET;
        end else if (boot_q == HSF_BOOT_LOAD) begin
            feature_q[HSF_SPREAD_BIT] <= scl_s2_q;
        end else if (cfg_wr && cfg_addr == HSF_FEATURE_OFS) begin
            feature_q[HSF_SPREAD_BIT] <= cfg_wdata[HSF_SPREAD_BIT];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            charge_q <= HSF_CHARGE_RESET;
        end else if (cfg_wr && cfg_addr == HSF_CHARGE_OFS) begin
            charge_q[HSF_CHARGE_MSB:0] <= cfg_wdata[HSF_CHARGE_MSB:0];
        end
    end

    // Reserved bits above the stored fields are never written and read as zero.
    always_comb begin
        rdata_d = 8'h00;
        if (in_text) begin
            rdata_d = text_mem[text_idx];
        end else if (cfg_addr == HSF_FEATURE_OFS) begin
            rdata_d = feature_q;
        end else if (cfg_addr == HSF_CHARGE_OFS) begin
            rdata_d = charge_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
            rack_q <= 1'b0;
        end else begin
            rack_q <= cfg_rd;
            if (cfg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // String fetch: pick base and length by descriptor index.
    assign serial_len = ({1'b0, serial_text_length} > HSF_SERIAL_MAX) ? HSF_SERIAL_MAX
                                                                       : {1'b0, serial_text_length};
    always_comb begin
        sel_len = 7'h00;
        sel_base = HSF_SERIAL_IDX0;
        case (str_index)
            HSF_IDX_SERIAL: begin
                sel_len = serial_len;
                sel_base = HSF_SERIAL_IDX0;
            end
            HSF_IDX_PRODUCT: begin
                sel_len = product_text_length;
                sel_base = HSF_PRODUCT_IDX0;
            end
            HSF_IDX_MAKER: begin
                sel_len = maker_text_length;
                sel_base = HSF_MAKER_IDX0;
            end
            default: begin
                sel_len = 7'h00;
                sel_base = HSF_SERIAL_IDX0;
            end
        endcase
    end
    assign sel_ok = (sel_len != 7'h00) && (str_pos < sel_len);
    assign fetch_idx = sel_base + {1'b0, str_pos};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sack_q <= 1'b0;
            spres_q <= 1'b0;
            sbyte_q <= 8'h00;
        end else begin
            sack_q <= str_req;
            if (str_req) begin
                spres_q <= sel_ok;
                sbyte_q <= sel_ok ? text_mem[fetch_idx] : 8'h00;
            end
        end
    end

    // Charging mode change: hold port power off for (field + 1) steps.
    assign start = charge_mode_change && downstream_charge_ctrl_enable;

    hsf_tick_div #(
        .PERIOD(DELAY_STEP_CYCLES)
    ) u_step (
        .mclk(mclk),
        .nrst(nrst),
        .restart(start),
        .tick(step_tick)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            HSF_PWR_RUN: begin
                if (start) begin
                    state_d = HSF_PWR_HOLD;
                end
            end
            HSF_PWR_HOLD: begin
                if (!start && step_tick && steps_q == 4'h1) begin
                    state_d = HSF_PWR_RUN;
                end
            end
            default: begin
                state_d = HSF_PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= HSF_PWR_RUN;
            steps_q <= 4'h0;
        end else begin
            state_q <= state_d;
            if (start) begin
                steps_q <= {1'b0, charge_q[HSF_DELAY_MSB:HSF_DELAY_LSB]} + 4'h1;
            end else if (state_q == HSF_PWR_HOLD && step_tick) begin
                steps_q <= steps_q - 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pwr_q <= 1'b0;
        end else begin
            pwr_q <= port_power_request && (state_d == HSF_PWR_RUN);
        end
    end

    // Helper logic read only by the checks below.
    logic [7:0] chk_idx_q;
    logic [7:0] chk_old_q;
    logic [2:0] chk_field_q;
    int unsigned chk_len_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chk_idx_q <= 8'h00;
            chk_old_q <= 8'h00;
            chk_field_q <= 3'h0;
            chk_len_q <= 0;
        end else begin
            chk_idx_q <= text_idx;
            chk_old_q <= in_text ? text_mem[text_idx] : 8'h00;
            if (start) begin
                chk_field_q <= charge_q[HSF_DELAY_MSB:HSF_DELAY_LSB];
                chk_len_q <= 1;
            end else if (state_q == HSF_PWR_HOLD) begin
                chk_len_q <= chk_len_q + 1;
            end
        end
    end

    property p_serial_locked;
        @(posedge mclk) disable iff (!nrst)
        cfg_wr && in_serial && !custom_serial_option |=> text_mem[chk_idx_q] == chk_old_q;
    endproperty
    a_serial_locked: assert property (p_serial_locked) else $error("serial byte changed while locked");

    property p_text_store;
        @(posedge mclk) disable iff (!nrst)
        text_wr |=> text_mem[chk_idx_q] == $past(cfg_wdata);
    endproperty
    a_text_store: assert property (p_text_store) else $error("text byte not stored at its offset");

    property p_boot_spread;
        @(posedge mclk) disable iff (!nrst)
        boot_q == HSF_BOOT_LOAD |=> spread_disable == $past(scl_s2_q);
    endproperty
    a_boot_spread: assert property (p_boot_spread) else $error("spread bit not loaded from pin");

    property p_rsvd_zero;
        @(posedge mclk) disable iff (!nrst)
        cfg_rd && (cfg_addr == HSF_FEATURE_OFS || cfg_addr == HSF_CHARGE_OFS) |=> cfg_ack && cfg_rdata[7:4] == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read non-zero");

    property p_serial_fetch;
        @(posedge mclk) disable iff (!nrst)
        str_req && str_index == HSF_IDX_SERIAL && str_pos >= serial_len |=> str_ack && !str_present;
    endproperty
    a_serial_fetch: assert property (p_serial_fetch) else $error("serial byte past length");

    property p_maker_len;
        @(posedge mclk) disable iff (!nrst)
        str_req && str_index == HSF_IDX_MAKER && str_pos < maker_text_length |=> str_present;
    endproperty
    a_maker_len: assert property (p_maker_len) else $error("maker byte missing");

    property p_product_len;
        @(posedge mclk) disable iff (!nrst)
        str_req && str_index == HSF_IDX_PRODUCT && str_pos >= product_text_length |=> !str_present && str_byte == 8'h00;
    endproperty
    a_product_len: assert property (p_product_len) else $error("product byte past length");

    property p_hold_off;
        @(posedge mclk) disable iff (!nrst)
        start |=> !port_power_enable ##0 state_q == HSF_PWR_HOLD;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("power not held off on mode change");

    property p_hold_len;
        @(posedge mclk) disable iff (!nrst)
        state_q == HSF_PWR_HOLD && state_d == HSF_PWR_RUN |->
            chk_len_q == (int'(chk_field_q) + 1) * int'(DELAY_STEP_CYCLES);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("power-on delay length wrong");

    property p_field_write;
        @(posedge mclk) disable iff (!nrst)
        cfg_wr && cfg_addr == HSF_CHARGE_OFS |=> charge_q[HSF_DELAY_MSB:HSF_DELAY_LSB] == $past(cfg_wdata[3:1]);
    endproperty
    a_field_write: assert property (p_field_write) else $error("delay field not written");

    c_hold_done: cover property (@(posedge mclk) disable iff (!nrst) state_q == HSF_PWR_HOLD ##1 state_q == HSF_PWR_RUN);
    c_serial_hit: cover property (@(posedge mclk) disable iff (!nrst) str_ack && str_present);
    c_spread_set: cover property (@(posedge mclk) disable iff (!nrst) spread_disable);
endmodule

/* File: testbench/hsf_eeprom_model.sv */
// Purpose: Model of the configuration EEPROM loader that writes the register byte port.
// Assumes: The byte port takes one write per cycle, back to back.
// Notes: String text is stored as little-endian 16-bit code units.
`timescale 1ns/1ps
module hsf_eeprom_model (
    // Clock.
    input wire logic mclk,
    // Control.
    input wire logic start,
    output logic done,
    // Write side of the byte port.
    output logic ld_wr,
    output logic [7:0] ld_addr,
    output logic [7:0] ld_wdata
);
    logic [15:0] image [0:8];
    initial begin
        image[0] = 16'h5048;
        image[1] = 16'h5100;
        image[2] = 16'h5269;
        image[3] = 16'h5300;
        image[4] = 16'h904f;
        image[5] = 16'h9100;
        image[6] = 16'h926b;
        image[7] = 16'h9300;
        image[8] = 16'hf202;
        done = 1'b0;
        ld_wr = 1'b0;
        ld_addr = 8'h00;
        ld_wdata = 8'h00;
        forever begin
            @(posedge mclk);
            if (start && !done) begin
                for (int i = 0; i < 9; i++) begin
                    ld_wr <= 1'b1;
                    ld_addr <= image[i][15:8];
                    ld_wdata <= image[i][7:0];
                    @(posedge mclk);
                end
                ld_wr <= 1'b0;
                ld_wdata <= ~image[8][7:0];
                done <= 1'b1;
            end
        end
    end
endmodule

/* File: testbench/hsf_regs_tb.sv */
// Purpose: Self-checking bench of the string and feature register bank.
// Assumes: The charging delay step is shortened to STEP cycles.
// Notes: The loader model and the bench share the byte port through a mux.
`timescale 1ns/1ps
module hsf_regs_tb;
    import hsf_pkg::*;
    localparam int unsigned STEP = 5;
    logic mclk, nrst, tb_wr, cfg_rd, cfg_ack, ld_wr, ld_start, ld_done, custom_serial_option;
    logic [7:0] tb_addr, tb_wdata, ld_addr, ld_wdata, cfg_rdata, str_byte, rd;
    logic str_req, str_ack, str_present, scl_pin, spread_disable, charge_mode_change;
    logic downstream_charge_ctrl_enable, port_power_request, port_power_enable;
    logic [5:0] serial_text_length;
    logic [6:0] maker_text_length, product_text_length, str_pos;
    logic [1:0] str_index;
    logic [7:0] maker_exp [0:3] = '{8'h48, 8'h00, 8'h69, 8'h00};
    logic [7:0] product_exp [0:2] = '{8'h4f, 8'h00, 8'h6b};
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    hsf_regs #(.DELAY_STEP_CYCLES(STEP), .SERIAL_RESET_BYTE(8'h00)) hsf_regs_i (
        .mclk(mclk), .nrst(nrst), .cfg_wr(tb_wr | ld_wr), .cfg_rd(cfg_rd),
        .cfg_addr(ld_wr ? ld_addr : tb_addr), .cfg_wdata(ld_wr ? ld_wdata : tb_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .custom_serial_option(custom_serial_option),
        .serial_text_length(serial_text_length), .maker_text_length(maker_text_length),
        .product_text_length(product_text_length), .str_req(str_req), .str_index(str_index),
        .str_pos(str_pos), .str_ack(str_ack), .str_present(str_present), .str_byte(str_byte),
        .scl_pin(scl_pin), .spread_disable(spread_disable),
        .downstream_charge_ctrl_enable(downstream_charge_ctrl_enable),
        .charge_mode_change(charge_mode_change), .port_power_request(port_power_request),
        .port_power_enable(port_power_enable));
    hsf_eeprom_model hsf_eeprom_model_i (
        .mclk(mclk), .start(ld_start), .done(ld_done), .ld_wr(ld_wr), .ld_addr(ld_addr),
        .ld_wdata(ld_wdata));
    task automatic summarize;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        tb_wr <= 1'b1;
        tb_addr <= a;
        tb_wdata <= d;
        @(posedge mclk);
        tb_wr <= 1'b0;
    endtask
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cfg_rd <= 1'b1;
        tb_addr <= a;
        @(posedge mclk);
        cfg_rd <= 1'b0;
        #1;
        cmp_bit(cfg_ack, 1'b1);
        cmp_byte(cfg_rdata, exp);
    endtask
    task automatic fetch(input logic [1:0] idx, input logic [6:0] pos, input logic ep, input logic [7:0] eb);
        @(posedge mclk);
        str_req <= 1'b1;
        str_index <= idx;
        str_pos <= pos;
        @(posedge mclk);
        str_req <= 1'b0;
        #1;
        cmp_bit(str_ack, 1'b1);
        cmp_bit(str_present, ep);
        cmp_byte(str_byte, eb);
    endtask
    task automatic t_boot;
        cmp_bit(spread_disable, 1'b1);
        check_reg(HSF_FEATURE_OFS, 8'h01);
        check_reg(HSF_MAKER_BASE, 8'h00);
        check_reg(HSF_SERIAL_BASE, 8'h00);
        check_reg(HSF_CHARGE_OFS, 8'h00);
        check_reg(8'h20, 8'h00);
    endtask
    task automatic t_feature;
        @(posedge mclk);
        scl_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        cmp_bit(spread_disable, 1'b1);
        cfg_write(HSF_FEATURE_OFS, 8'hfe);
        check_reg(HSF_FEATURE_OFS, 8'h00);
        cmp_bit(spread_disable, 1'b0);
        cfg_write(HSF_FEATURE_OFS, 8'hff);
        check_reg(HSF_FEATURE_OFS, 8'h01);
        cmp_bit(spread_disable, 1'b1);
    endtask
    task automatic t_serial;
        cfg_write(8'h30, 8'ha5);
        check_reg(8'h30, 8'h00);
        @(posedge mclk);
        custom_serial_option <= 1'b1;
        serial_text_length <= 6'h02;
        cfg_write(8'h30, 8'ha5);
        cfg_write(8'h31, 8'h5a);
        cfg_write(8'h4f, 8'h3c);
        check_reg(8'h31, 8'h5a);
        fetch(HSF_IDX_SERIAL, 7'h00, 1'b1, 8'ha5);
        fetch(HSF_IDX_SERIAL, 7'h01, 1'b1, 8'h5a);
        fetch(HSF_IDX_SERIAL, 7'h02, 1'b0, 8'h00);
        @(posedge mclk);
        serial_text_length <= 6'h28;
        fetch(HSF_IDX_SERIAL, 7'h1f, 1'b1, 8'h3c);
        fetch(HSF_IDX_SERIAL, 7'h20, 1'b0, 8'h00);
        fetch(2'h0, 7'h00, 1'b0, 8'h00);
    endtask
    task automatic t_strings;
        int n;
        n = 0;
        @(posedge mclk);
        ld_start <= 1'b1;
        while (ld_done !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        cmp_bit(ld_done, 1'b1);
        fetch(HSF_IDX_MAKER, 7'h00, 1'b0, 8'h00);
        @(posedge mclk);
        maker_text_length <= 7'h04;
        product_text_length <= 7'h03;
        for (int i = 0; i < 4; i++) fetch(HSF_IDX_MAKER, 7'(i), 1'b1, maker_exp[i]);
        fetch(HSF_IDX_MAKER, 7'h04, 1'b0, 8'h00);
        for (int i = 0; i < 3; i++) fetch(HSF_IDX_PRODUCT, 7'(i), 1'b1, product_exp[i]);
        fetch(HSF_IDX_PRODUCT, 7'h03, 1'b0, 8'h00);
        @(posedge mclk);
        product_text_length <= 7'h00;
        fetch(HSF_IDX_PRODUCT, 7'h00, 1'b0, 8'h00);
    endtask
    task automatic t_charge;
        int low;
        low = 0;
        check_reg(HSF_CHARGE_OFS, 8'h02);
        cfg_write(HSF_CHARGE_OFS, 8'hff);
        check_reg(HSF_CHARGE_OFS, 8'h0f);
        cfg_write(HSF_CHARGE_OFS, 8'h02);
        cmp_bit(port_power_enable, 1'b1);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            downstream_charge_ctrl_enable <= (k == 0);
            charge_mode_change <= 1'b1;
            @(posedge mclk);
            charge_mode_change <= 1'b0;
            #1;
            if (port_power_enable !== 1'b1) low++;
            repeat (39) begin
                @(posedge mclk);
                #1;
                if (port_power_enable !== 1'b1) low++;
            end
            cmp_byte(8'(low), (k == 0) ? 8'(2 * STEP) : 8'h00);
            low = 0;
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        nrst = 1'b0;
        tb_wr = 1'b0;
        cfg_rd = 1'b0;
        tb_addr = 8'h00;
        tb_wdata = 8'h00;
        ld_start = 1'b0;
        custom_serial_option = 1'b0;
        serial_text_length = 6'h00;
        maker_text_length = 7'h00;
        product_text_length = 7'h00;
        str_req = 1'b0;
        str_index = 2'h0;
        str_pos = 7'h00;
        scl_pin = 1'b1;
        downstream_charge_ctrl_enable = 1'b0;
        charge_mode_change = 1'b0;
        port_power_request = 1'b1;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        t_boot();
        t_feature();
        t_serial();
        t_strings();
        t_charge();
        summarize();
    end
endmodule
